// >>> ddac_pkg.sv
// How it works
// - ack address and data bytes on ninth clock
// - release data in ack slot, await master ack
// - compare address bitwise, drop out on mismatch
// - address lsb selects write or read
// - upper address fixed, lowest from select pin
// - command nibble, data; update at eighth clock fall, as ack starts
// - aborted write leaves registers unchanged
// - all-ones command, zero nibble: extended mode
// - channel select bits take power mode
// - power modes: up, float, 1k, 100k
// - read sends output register as two bytes
// - no general call, no ten-bit addressing
// - gate clock on mismatch until next start
// - cmd 0000 loads a, updates b output
// - cmd 0001 loads b, updates a output
// - cmds 0100/0101 load input register only
// - cmds 1000/1001 transfer then load input
// - cmd 1100 loads all registers of both
// - cmd 1101 loads both input registers only
// - cmd 1110 transfers inputs, no data byte
// - cmd 1111 0001/0010 selects readback channel
// - reset: outputs zero, both in 100k mode
package ddac_pkg;
    // upper six address bits; value arbitrary
    localparam logic [5:0] ADDR_UPPER   = 6'h2a;
    localparam int         CODE_W       = 12;
    localparam logic [3:0] CMD_LD_A_UPB = 4'h0;
    localparam logic [3:0] CMD_LD_B_UPA = 4'h1;
    localparam logic [3:0] CMD_IN_A     = 4'h4;
    localparam logic [3:0] CMD_IN_B     = 4'h5;
    localparam logic [3:0] CMD_UP_IN_A  = 4'h8;
    localparam logic [3:0] CMD_UP_IN_B  = 4'h9;
    localparam logic [3:0] CMD_LD_ALL   = 4'hc;
    localparam logic [3:0] CMD_IN_ALL   = 4'hd;
    localparam logic [3:0] CMD_UPDATE   = 4'he;
    localparam logic [3:0] CMD_EXT      = 4'hf;
    localparam logic [3:0] SUB_EXT      = 4'h0;
    localparam logic [3:0] SUB_RD_A     = 4'h1;
    localparam logic [3:0] SUB_RD_B     = 4'h2;
    localparam logic [1:0] PM_UP        = 2'h0;
    localparam logic [1:0] PM_100K      = 2'h3;
    localparam logic [3:0] BIT_LAST     = 4'h7;
    localparam logic [3:0] BIT_ACK      = 4'h8;
    // extended byte field positions
    localparam int         EXT_SEL_A    = 2;
    localparam int         EXT_SEL_B    = 3;
    // serial interface phases
    typedef enum logic [2:0] {
        DDAC_IDLE  = 3'b000,
        DDAC_ADDR  = 3'b001,
        DDAC_WR    = 3'b010,
        DDAC_RD    = 3'b011,
        DDAC_RDACK = 3'b100
    } ddac_state_t;
endpackage

// >>> ddac_slave.sv
`timescale 1ns/100ps
`default_nettype none
module ddac_slave (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        address_bit_zero_in,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    output logic [11:0]      out_code_a_out,
    output logic [11:0]      out_code_b_out,
    output logic [1:0]       power_mode_a_out,
    output logic [1:0]       power_mode_b_out,
    output logic             clock_gated_out
);
    ////////////////////////////////////////////////////////////////////
    // state record
    typedef struct packed {
        ddac_pkg::ddac_state_t st;    // interface phase
        logic        scl_q;           // sampled clock
        logic        sda_q;           // sampled data
        logic        gated;           // clock disconnected
        logic [3:0]  bitn;            // bit within word
        logic [7:0]  shreg;           // shift register
        logic [1:0]  bytes;           // bytes taken this write
        logic [7:0]  cmd;             // first data byte
        logic        ack;             // ack slot active
        logic        ext;             // next byte is power byte
        logic        sel_b;           // readback channel
        logic        rd2;             // second read byte
        logic        drv_low;         // pull data low
        logic [11:0] in_a;            // input registers
        logic [11:0] in_b;
        logic [11:0] out_a;           // output registers
        logic [11:0] out_b;
        logic [1:0]  pm_a;            // power modes
        logic [1:0]  pm_b;
    } ddac_regs_t;

    ddac_regs_t r;
    ddac_regs_t next_r;

    ////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic        rise;
        logic        fall;
        logic        start;
        logic        stop;
        logic [11:0] code;
        logic [6:0]  my_addr;
        rise    = 1'b0;
        fall    = 1'b0;
        start   = 1'b0;
        stop    = 1'b0;
        code    = 12'h000;
        my_addr = 7'h00;
        next_r  = r;
        next_r.scl_q = scl_in;
        next_r.sda_q = sda_in;
        rise  = scl_in & ~r.scl_q;
        fall  = ~scl_in & r.scl_q;
        start = scl_in & r.scl_q & r.sda_q & ~sda_in;
        stop  = scl_in & r.scl_q & ~r.sda_q & sda_in;
        my_addr = {ddac_pkg::ADDR_UPPER, address_bit_zero_in};
        code  = {r.cmd[3:0], r.shreg};
        if (start) begin
            next_r.gated   = 1'b0;
            next_r.st      = ddac_pkg::DDAC_ADDR;
            // the fall that closes the start wraps the count to bit zero
            next_r.bitn    = '1;
            next_r.ack     = 1'b0;
            next_r.drv_low = 1'b0;
            next_r.bytes   = 2'h0;
            next_r.ext     = 1'b0;
        end else if (stop) begin
            // stop before ack drops partial word
            next_r.st      = ddac_pkg::DDAC_IDLE;
            next_r.drv_low = 1'b0;
            next_r.gated   = 1'b1;
        end else if (!r.gated && r.st != ddac_pkg::DDAC_IDLE) begin
            if (rise && !r.ack) begin
                // sending side shifts on falls only
                if (r.st != ddac_pkg::DDAC_RD) next_r.shreg = {r.shreg[6:0], sda_in};
                if (r.st == ddac_pkg::DDAC_ADDR && r.bitn != ddac_pkg::BIT_LAST
                    && sda_in != my_addr[3'h6 - r.bitn[2:0]]) begin
                    next_r.gated = 1'b1;
                    next_r.st    = ddac_pkg::DDAC_IDLE;
                end
                if (r.st == ddac_pkg::DDAC_RDACK && sda_in)
                    next_r.st = ddac_pkg::DDAC_IDLE;
            end else if (fall) begin
                if (r.ack) begin
                    // end of ack slot
                    next_r.ack     = 1'b0;
                    next_r.drv_low = 1'b0;
                    next_r.bitn    = 4'h0;
                    if (r.st == ddac_pkg::DDAC_RD) begin
                        // first read bit: msb of the loaded byte
                        next_r.drv_low = ~r.shreg[7];
                    end
                end else if (r.bitn == ddac_pkg::BIT_LAST) begin
                    next_r.bitn = ddac_pkg::BIT_ACK;
                    case (r.st)
                        ddac_pkg::DDAC_ADDR: begin
                            next_r.ack     = 1'b1;
                            next_r.drv_low = 1'b1;
                            if (r.shreg[0]) begin
                                next_r.st  = ddac_pkg::DDAC_RD;
                                next_r.rd2 = 1'b0;
                                next_r.shreg = r.sel_b ? {4'h0, r.out_b[11:8]}
                                                       : {4'h0, r.out_a[11:8]};
                            end else begin
                                next_r.st = ddac_pkg::DDAC_WR;
                            end
                        end
                        ddac_pkg::DDAC_WR: begin
                            next_r.ack     = 1'b1;
                            next_r.drv_low = 1'b1;
                            next_r.bytes   = r.bytes + 2'h1;
                            if (r.ext) begin
                                if (r.shreg[ddac_pkg::EXT_SEL_A]) next_r.pm_a = r.shreg[1:0];
                                if (r.shreg[ddac_pkg::EXT_SEL_B]) next_r.pm_b = r.shreg[1:0];
                                next_r.ext   = 1'b0;
                                next_r.bytes = 2'h0;
                            end else if (r.bytes == 2'h0) begin
                                next_r.cmd = r.shreg;
                                if (r.shreg[7:4] == ddac_pkg::CMD_UPDATE) begin
                                    next_r.out_a = r.in_a;
                                    next_r.out_b = r.in_b;
                                    next_r.bytes = 2'h0;
                                end else if (r.shreg[7:4] == ddac_pkg::CMD_EXT) begin
                                    next_r.bytes = 2'h0;
                                    if (r.shreg[3:0] == ddac_pkg::SUB_EXT) next_r.ext = 1'b1;
                                    if (r.shreg[3:0] == ddac_pkg::SUB_RD_A) next_r.sel_b = 1'b0;
                                    if (r.shreg[3:0] == ddac_pkg::SUB_RD_B) next_r.sel_b = 1'b1;
                                end
                            end else begin
                                next_r.bytes = 2'h0;
                                code = {r.cmd[3:0], r.shreg};
                                case (r.cmd[7:4])
                                    ddac_pkg::CMD_LD_A_UPB: begin
                                        next_r.in_a = code;
                                        next_r.out_a = code;
                                        next_r.out_b = r.in_b;
                                    end
                                    ddac_pkg::CMD_LD_B_UPA: begin
                                        next_r.in_b = code;
                                        next_r.out_b = code;
                                        next_r.out_a = r.in_a;
                                    end
                                    ddac_pkg::CMD_IN_A: next_r.in_a = code;
                                    ddac_pkg::CMD_IN_B: next_r.in_b = code;
                                    ddac_pkg::CMD_UP_IN_A: begin
                                        next_r.out_a = r.in_a;
                                        next_r.out_b = r.in_b;
                                        next_r.in_a = code;
                                    end
                                    ddac_pkg::CMD_UP_IN_B: begin
                                        next_r.out_a = r.in_a;
                                        next_r.out_b = r.in_b;
                                        next_r.in_b = code;
                                    end
                                    ddac_pkg::CMD_LD_ALL: begin
                                        next_r.in_a = code;
                                        next_r.in_b = code;
                                        next_r.out_a = code;
                                        next_r.out_b = code;
                                    end
                                    ddac_pkg::CMD_IN_ALL: begin
                                        next_r.in_a = code;
                                        next_r.in_b = code;
                                    end
                                    default: next_r.bytes = 2'h0;
                                endcase
                            end
                        end
                        ddac_pkg::DDAC_RD: begin
                            next_r.ack     = 1'b0;
                            next_r.drv_low = 1'b0;
                            next_r.bitn    = 4'h0;
                            next_r.st      = ddac_pkg::DDAC_RDACK;
                        end
                        default: next_r.st = ddac_pkg::DDAC_IDLE;
                    endcase
                end else begin
                    next_r.bitn = r.bitn + 4'h1;
                    if (r.st == ddac_pkg::DDAC_RD) begin
                        next_r.shreg   = {r.shreg[6:0], 1'b0};
                        next_r.drv_low = ~r.shreg[6];
                    end
                end
            end else if (fall && r.st == ddac_pkg::DDAC_RDACK) begin
                next_r.drv_low = 1'b0;
            end
            // after master ack: send second byte
            if (fall && r.st == ddac_pkg::DDAC_RDACK && r.bitn == 4'h0 && !r.ack) begin
                if (!r.rd2) begin
                    next_r.st      = ddac_pkg::DDAC_RD;
                    next_r.rd2     = 1'b1;
                    next_r.bitn    = 4'h0;
                    next_r.shreg   = r.sel_b ? r.out_b[7:0] : r.out_a[7:0];
                    next_r.drv_low = r.sel_b ? ~r.out_b[7] : ~r.out_a[7];
                end else begin
                    next_r.st = ddac_pkg::DDAC_IDLE;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            r       <= '0;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.gated <= 1'b1;
            r.pm_a  <= ddac_pkg::PM_100K;
            r.pm_b  <= ddac_pkg::PM_100K;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the record; data pin value tied low
    assign sda_out          = 1'b0;
    assign sda_oe_n_out     = ~r.drv_low;
    assign out_code_a_out   = r.out_a;
    assign out_code_b_out   = r.out_b;
    assign power_mode_a_out = r.pm_a;
    assign power_mode_b_out = r.pm_b;
    assign clock_gated_out  = r.gated;
endmodule // ddac_slave
`default_nettype wire

// >>> ddac_master.sv
`timescale 1ns/100ps
`default_nettype none
// two-wire bus master model; scl idles high between frames
module ddac_master (
    input  wire logic clk_in,
    input  wire logic sda_line_in,
    output var logic  scl_out,
    output var logic  sda_drv_out
);
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end
    // wait whole system clocks; changes land just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // start or repeated start, bus clock left low
    task automatic start();
        sda_drv_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_drv_out <= 1'b0;
        tick(4);
        scl_out <= 1'b0;
        tick(1);
    endtask
    // one bit: data set while low, line sampled at end of high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_drv_out <= b;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        s = sda_line_in;
        scl_out <= 1'b0;
        tick(1);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, ack);
    endtask
    // released line while slave sends; mack low asks for more
    task automatic get_byte(input logic mack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(mack, s);
    endtask
    task automatic stop();
        sda_drv_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_drv_out <= 1'b1;
        tick(4);
    endtask
endmodule // ddac_master
`default_nettype wire

// >>> ddac_properties.sv
`timescale 1ns/100ps
`default_nettype none
// port-level timing relations of the serial slave
module ddac_properties (
    input wire logic        clk_sys_in,
    input wire logic        rst_in,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        address_bit_zero_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_n_out,
    input wire logic [11:0] out_code_a_out,
    input wire logic [11:0] out_code_b_out,
    input wire logic [1:0]  power_mode_a_out,
    input wire logic [1:0]  power_mode_b_out,
    input wire logic        clock_gated_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    chk_reset_state: assert property (disable iff (1'b0) rst_in ##1 rst_in |->
        out_code_a_out == 12'h000 && out_code_b_out == 12'h000 && power_mode_a_out == 2'h3
        && power_mode_b_out == 2'h3 && sda_oe_n_out && clock_gated_out) else $error("reset state");
    chk_pin_low: assert property (!sda_oe_n_out |-> !sda_out) else $error("drive not low");
    chk_gated_quiet: assert property (clock_gated_out |-> sda_oe_n_out) else $error("gated drive");
    chk_gated_hold: assert property (clock_gated_out && $past(clock_gated_out) |->
        $stable(out_code_a_out) && $stable(out_code_b_out) && $stable(power_mode_a_out)
        && $stable(power_mode_b_out)) else $error("change while gated");
    chk_code_update: assert property (($changed(out_code_a_out) || $changed(out_code_b_out))
        |-> !scl_in) else $error("code changed with bus clock high");
    chk_mode_update: assert property (($changed(power_mode_a_out) || $changed(power_mode_b_out))
        |-> !scl_in) else $error("mode changed with bus clock high");
    chk_drive_launch: assert property ($fell(sda_oe_n_out) |-> !scl_in) else $error("late drive");
    chk_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n_out))
        else $error("data moved while clock high");
    chk_ungate_start: assert property ($fell(clock_gated_out) |-> scl_in && !sda_in)
        else $error("ungated without start");
    cover property ($fell(sda_oe_n_out));
    cover property ($changed(out_code_b_out));
    cover property ($rose(clock_gated_out));
endmodule // ddac_properties
bind ddac_slave ddac_properties u_ddac_properties (.clk_sys_in, .rst_in, .scl_in, .sda_in,
    .address_bit_zero_in, .sda_out, .sda_oe_n_out, .out_code_a_out, .out_code_b_out,
    .power_mode_a_out, .power_mode_b_out, .clock_gated_out);
`default_nettype wire

// >>> tb.sv
`timescale 1ns/100ps
`default_nettype none
// bench for the serial slave and command decoder
module tb;
    logic        clk_sys_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic        pin        = 1'b0;          // address select pin
    logic        scl, sda_drv, sda_o, sda_oe_n, gated;
    logic [11:0] code_a, code_b, in_a, in_b, ex_a, ex_b; // seen and expected codes
    logic [1:0]  mode_a, mode_b, pm_a, pm_b;
    int          err_total, samples_checked, cyc;
    wire         sda_line = sda_drv & (sda_oe_n | sda_o); // pulled-up shared wire
    ddac_slave u_ddac_slave (.clk_sys_in, .rst_in, .scl_in(scl), .sda_in(sda_line),
        .address_bit_zero_in(pin), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
        .out_code_a_out(code_a), .out_code_b_out(code_b), .power_mode_a_out(mode_a),
        .power_mode_b_out(mode_b), .clock_gated_out(gated));
    ddac_master u_ddac_master (.clk_in(clk_sys_in), .sda_line_in(sda_line), .scl_out(scl),
        .sda_drv_out(sda_drv));
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // write frame without stop: address, command byte, optional data byte
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input bit two);
        logic a0, a1, a2;
        a2 = 1'b0;
        u_ddac_master.start();
        u_ddac_master.put_byte({ddac_pkg::ADDR_UPPER, pin, 1'b0}, a0);
        u_ddac_master.put_byte(c, a1);
        if (two) u_ddac_master.put_byte(d, a2);
        check({a0, a1, a2}, 32'h0);
    endtask
    task automatic t_reset();
        @(posedge clk_sys_in);
        check({code_a, code_b, mode_a, mode_b, gated, sda_oe_n}, {24'h0, 6'h3f});
        $display("reset test done");
    endtask
    // every command nibble but the extended one, undefined ones included
    task automatic t_cmds();
        logic [11:0] d, na, nb;
        for (logic [4:0] c = 5'h0; c < 5'hf; c++) begin
            d = 12'h7c3 ^ {c[3:0], c[3:0], c[3:0]};
            wr({c[3:0], d[11:8]}, d[7:0], c != 5'he);
            u_ddac_master.stop();
            na = (c inside {5'h0, 5'h4, 5'h8, 5'hc, 5'hd}) ? d : in_a;
            nb = (c inside {5'h1, 5'h5, 5'h9, 5'hc, 5'hd}) ? d : in_b;
            ex_a = (c inside {5'h0, 5'hc}) ? d : (c inside {5'h1, 5'h8, 5'h9, 5'he}) ? in_a : ex_a;
            ex_b = (c inside {5'h1, 5'hc}) ? d : (c inside {5'h0, 5'h8, 5'h9, 5'he}) ? in_b : ex_b;
            in_a = na;
            in_b = nb;
            check({code_a, code_b, mode_a, mode_b}, {ex_a, ex_b, pm_a, pm_b});
        end
        $display("command test done");
    endtask
    // power modes through the extended byte: both, a, b, both, both
    task automatic t_ext();
        logic [1:0] s;
        for (int k = 0; k < 5; k++) begin
            s = (k == 1) ? 2'h1 : (k == 2) ? 2'h2 : 2'h3;
            wr(8'hf0, {4'h0, s, 2'(k)}, 1'b1);
            u_ddac_master.stop();
            pm_a = s[0] ? 2'(k) : pm_a;
            pm_b = s[1] ? 2'(k) : pm_b;
            check({code_a, code_b, mode_a, mode_b}, {ex_a, ex_b, pm_a, pm_b});
        end
        $display("power mode test done");
    endtask
    // data byte cut short by a stop
    task automatic t_abort();
        logic s;
        wr(8'hc3, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) u_ddac_master.clk_bit(1'b1, s);
        u_ddac_master.stop();
        check({code_a, code_b}, {ex_a, ex_b});
        $display("abort test done");
    endtask
    // pin high, then own upper bits with pin bit low, foreign, general call and ten-bit style addresses
    task automatic t_miss();
        logic ak;
        logic [7:0] al [4];
        pin <= 1'b1;
        al = '{{ddac_pkg::ADDR_UPPER, 2'h0}, {ddac_pkg::ADDR_UPPER ^ 6'h20, 2'h2}, 8'h00, 8'hf0};
        foreach (al[i]) begin
            u_ddac_master.start();
            u_ddac_master.put_byte(al[i], ak);
            check({ak, gated}, 32'h3);
            u_ddac_master.stop();
        end
        $display("address test done");
    endtask
    // readback of each channel after a select command
    task automatic t_read();
        logic ak;
        logic [7:0] h, l;
        for (int ch = 0; ch < 2; ch++) begin
            wr({4'hf, ch ? 4'h2 : 4'h1}, 8'h00, 1'b0);
            u_ddac_master.start();
            u_ddac_master.put_byte({ddac_pkg::ADDR_UPPER, pin, 1'b1}, ak);
            u_ddac_master.get_byte(1'b0, h);
            u_ddac_master.get_byte(1'b1, l);
            u_ddac_master.stop();
            check({ak, h, l}, {1'b0, 4'h0, ch ? ex_b : ex_a});
        end
        $display("read test done");
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard on the cycle count
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {in_a, in_b, ex_a, ex_b} = 48'h0;
        {pm_a, pm_b} = 4'hf;
        repeat (6) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_reset();
        t_cmds();
        t_ext();
        t_abort();
        t_miss();
        t_read();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
